// *** iop_regs.svh ***
// Register offsets, field positions, reset values and constants of the port block.
// Overview of operation
// - A set pull-high enable bit pulls the pin high only while it is an input.
// - Unused upper bits of port B and port C pull and direction read zero.
// - In sleep, a falling edge on a wake-enabled port A pin wakes the device.
// - Direction bit 1 makes the pin an input, 0 a driven CMOS output.
// - Reading port data of an input pin returns the live pin level.
// - Reading port data of an output pin returns the output latch.
// - Direction bits may change at any time and act at once.
// - An analog function on a pin wins over any digital function.
// - One pin's analog signal reaches every analog channel enabled on it.
// - Small variant bits 7:6: 00/10 bit5, 01 inverted timer, 11 channel 3.
// - Small variant bits 5:4: 00 bit2, 01 timer, 10 ref out, 11 channel 2.
// - Small variant bits 3:2: 00 bit1, 01 inverted timer, 10 ref in, 11 ch1.
// - Small variant bits 1:0: 00/10 bit0, 01 timer, 11 channel 0.
// - Mid bit 7 selects inverted timer on bit7, only with reset control 55H.
// - Mid bits 6 and 5 select timer out on bits 6 and 4 when set.
// - Mid bits 4 and 3 select channels 3 and 2 on bits 3 and 2.
// - Mid bits 2:1: 0X bit1, 10 ref in, 11 channel 1.
// - Mid bit 0 selects channel 0 on bit0 when set.
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define IOP_ADDR_W      4
`define IOP_A_PA_DATA   4'h0
`define IOP_A_PA_DIR    4'h1
`define IOP_A_PA_PULL   4'h2
`define IOP_A_PA_WAKE   4'h3
`define IOP_A_PA_SEL    4'h4
`define IOP_A_PB_DATA   4'h5
`define IOP_A_PB_DIR    4'h6
`define IOP_A_PB_PULL   4'h7
`define IOP_A_PC_DATA   4'h8
`define IOP_A_PC_DIR    4'h9
`define IOP_A_PC_PULL   4'hA
`define IOP_A_RST_CTRL  4'hB
`define IOP_A_IRQ_STAT  4'hC
`define IOP_A_IRQ_CLR   4'hD
`define IOP_A_IRQ_EN    4'hE

// ****************************************************************
// Reset values and keys.
// ****************************************************************
`define IOP_RST_DATA    8'hFF
`define IOP_RST_DIR     8'hFF
`define IOP_RST_ZERO    8'h00
`define IOP_RST_CTRL    8'h00
`define IOP_RST_UNLOCK  8'h55

// ****************************************************************
// Select field positions, small variant.
// ****************************************************************
`define IOP_SS_PA5      7:6
`define IOP_SS_PA2      5:4
`define IOP_SS_PA1      3:2
`define IOP_SS_PA0      1:0

// ****************************************************************
// Select field positions, mid variant.
// ****************************************************************
`define IOP_SM_PA7      7
`define IOP_SM_PA6      6
`define IOP_SM_PA4      5
`define IOP_SM_PA3      4
`define IOP_SM_PA2      3
`define IOP_SM_PA1      2:1
`define IOP_SM_PA0      0

`endif

// *** iop_pkg.sv ***
// Types shared by the port block.
`default_nettype none
package iop_pkg;
   typedef enum logic {
      IOP_VAR_SMALL = 1'b0,
      IOP_VAR_MID   = 1'b1
   } iop_variant_t;

   typedef enum logic [2:0] {
      IOP_FN_GPIO  = 3'b000,
      IOP_FN_TMR   = 3'b001,
      IOP_FN_TMRN  = 3'b010,
      IOP_FN_REF_VOLTAGE_OUT = 3'b011,
      IOP_FN_VREFI = 3'b100,
      IOP_FN_AN    = 3'b101
   } iop_fn_t;
endpackage : iop_pkg
`default_nettype wire

// *** iop_port_pull_wake_mux.sv ***
// Port direction, pull-high, port A wake-up and port A pin function select.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "iop_regs.svh"
module iop_port_pull_wake_mux #(
   parameter iop_pkg::iop_variant_t VARIANT  = iop_pkg::IOP_VAR_SMALL,
   parameter int                    PB_WIDTH = 6,
   parameter int                    PC_WIDTH = 3
) (
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Register port.
   input  wire logic [`IOP_ADDR_W-1:0] addr,
   input  wire logic [7:0]             wrData,
   input  wire logic                   wrStrobe,
   input  wire logic                   rdStrobe,
   output var  logic [7:0]             rdData,
   // Port A pins.
   input  wire logic [7:0]             paIn,
   output var  logic [7:0]             paOut,
   output var  logic [7:0]             paOe,
   output var  logic [7:0]             paPullEn,
   // Port B pins.
   input  wire logic [PB_WIDTH-1:0]    pbIn,
   output var  logic [PB_WIDTH-1:0]    pbOut,
   output var  logic [PB_WIDTH-1:0]    pbOe,
   output var  logic [PB_WIDTH-1:0]    pbPullEn,
   // Port C pins.
   input  wire logic [PC_WIDTH-1:0]    pcIn,
   output var  logic [PC_WIDTH-1:0]    pcOut,
   output var  logic [PC_WIDTH-1:0]    pcOe,
   output var  logic [PC_WIDTH-1:0]    pcPullEn,
   // Peripheral side.
   input  wire logic                   stdTimerOut,
   input  wire logic                   stdTimerOutN,
   input  wire logic                   refVoltageOut,
   output var  logic [7:0]             paDigIn,
   output var  logic [7:0]             paAnalogPin,
   output var  logic [3:0]             analogChEn,
   output var  logic                   refVoltageInEn,
   // Power control and interrupt.
   input  wire logic                   sleepMode,
   output var  logic                   wakeUp,
   output var  logic                   irq
);
   import iop_pkg::*;

   // ****************************************************************
   // Elaboration checks.
   // ****************************************************************
   if (PB_WIDTH < 1 || PB_WIDTH > 7) begin : g_chk_pb
      $error("PB_WIDTH must lie between 1 and 7.");
   end
   if (PC_WIDTH < 1 || PC_WIDTH > 7) begin : g_chk_pc
      $error("PC_WIDTH must lie between 1 and 7.");
   end

   // ****************************************************************
   // Pin function decode.
   // ****************************************************************
   // Returns the function chosen for one port A pin.
   function automatic iop_fn_t pinFn(input int pin, input logic [7:0] s,
                                     input logic unlocked);
      iop_fn_t f;
      f = IOP_FN_GPIO;
      if (VARIANT == IOP_VAR_SMALL) begin
         case (pin)
            0: case (s[`IOP_SS_PA0])
                  2'b01:   f = IOP_FN_TMR;
                  2'b11:   f = IOP_FN_AN;
                  default: f = IOP_FN_GPIO;
               endcase
            1: case (s[`IOP_SS_PA1])
                  2'b01:   f = IOP_FN_TMRN;
                  2'b10:   f = IOP_FN_VREFI;
                  2'b11:   f = IOP_FN_AN;
                  default: f = IOP_FN_GPIO;
               endcase
            2: case (s[`IOP_SS_PA2])
                  2'b01:   f = IOP_FN_TMR;
                  2'b10:   f = IOP_FN_REF_VOLTAGE_OUT;
                  2'b11:   f = IOP_FN_AN;
                  default: f = IOP_FN_GPIO;
               endcase
            5: case (s[`IOP_SS_PA5])
                  2'b01:   f = IOP_FN_TMRN;
                  2'b11:   f = IOP_FN_AN;
                  default: f = IOP_FN_GPIO;
               endcase
            default: f = IOP_FN_GPIO;
         endcase
      end else begin
         case (pin)
            0: if (s[`IOP_SM_PA0]) f = IOP_FN_AN;
            1: case (s[`IOP_SM_PA1])
                  2'b10:   f = IOP_FN_VREFI;
                  2'b11:   f = IOP_FN_AN;
                  default: f = IOP_FN_GPIO;
               endcase
            2: if (s[`IOP_SM_PA2]) f = IOP_FN_AN;
            3: if (s[`IOP_SM_PA3]) f = IOP_FN_AN;
            4: if (s[`IOP_SM_PA4]) f = IOP_FN_TMR;
            6: if (s[`IOP_SM_PA6]) f = IOP_FN_TMR;
            7: if (s[`IOP_SM_PA7] && unlocked) f = IOP_FN_TMRN;
            default: f = IOP_FN_GPIO;
         endcase
      end
      return f;
   endfunction : pinFn

   // Returns the analog channel bonded to one port A pin.
   function automatic logic [3:0] pinChan(input int pin);
      logic [3:0] c;
      c = 4'h0;
      if (VARIANT == IOP_VAR_SMALL) begin
         case (pin)
            0:       c = 4'h1;
            1:       c = 4'h2;
            2:       c = 4'h4;
            5:       c = 4'h8;
            default: c = 4'h0;
         endcase
      end else begin
         case (pin)
            0:       c = 4'h1;
            1:       c = 4'h2;
            2:       c = 4'h4;
            3:       c = 4'h8;
            default: c = 4'h0;
         endcase
      end
      return c;
   endfunction : pinChan

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [7:0]          paDataReg;
   logic [7:0]          paDirReg;
   logic [7:0]          paPullReg;
   logic [7:0]          paWakeReg;
   logic [7:0]          paSelReg;
   logic [PB_WIDTH-1:0] pbDataReg;
   logic [PB_WIDTH-1:0] pbDirReg;
   logic [PB_WIDTH-1:0] pbPullReg;
   logic [PC_WIDTH-1:0] pcDataReg;
   logic [PC_WIDTH-1:0] pcDirReg;
   logic [PC_WIDTH-1:0] pcPullReg;
   logic [7:0]          rstCtrlReg;
   logic [7:0]          irqStatReg;
   logic [7:0]          irqEnReg;
   logic [7:0]          paPrevReg;
   logic                wakeUpReg;
   logic [7:0]          rdDataReg;

   // ****************************************************************
   // Decode.
   // ****************************************************************
   wire logic       wrPaData  = wrStrobe && addr == `IOP_A_PA_DATA;
   wire logic       wrPaDir   = wrStrobe && addr == `IOP_A_PA_DIR;
   wire logic       wrPaPull  = wrStrobe && addr == `IOP_A_PA_PULL;
   wire logic       wrPaWake  = wrStrobe && addr == `IOP_A_PA_WAKE;
   wire logic       wrPaSel   = wrStrobe && addr == `IOP_A_PA_SEL;
   wire logic       wrPbData  = wrStrobe && addr == `IOP_A_PB_DATA;
   wire logic       wrPbDir   = wrStrobe && addr == `IOP_A_PB_DIR;
   wire logic       wrPbPull  = wrStrobe && addr == `IOP_A_PB_PULL;
   wire logic       wrPcData  = wrStrobe && addr == `IOP_A_PC_DATA;
   wire logic       wrPcDir   = wrStrobe && addr == `IOP_A_PC_DIR;
   wire logic       wrPcPull  = wrStrobe && addr == `IOP_A_PC_PULL;
   wire logic       wrRstCtrl = wrStrobe && addr == `IOP_A_RST_CTRL;
   wire logic       wrIrqClr  = wrStrobe && addr == `IOP_A_IRQ_CLR;
   wire logic       wrIrqEn   = wrStrobe && addr == `IOP_A_IRQ_EN;
   wire logic       unlocked  = rstCtrlReg == `IOP_RST_UNLOCK;
   wire logic [7:0] clrMask   = wrIrqClr ? wrData : `IOP_RST_ZERO;

   // ****************************************************************
   // Port A pin logic.
   // ****************************************************************
   iop_fn_t    paFn [8];
   logic [7:0] paAn;
   logic [7:0] paVrefIn;
   logic [3:0] paChan [8];

   for (genvar i = 0; i < 8; i++) begin : g_pa
      assign paFn[i]     = pinFn(i, paSelReg, unlocked);
      assign paAn[i]     = paFn[i] == IOP_FN_AN;
      assign paVrefIn[i] = paFn[i] == IOP_FN_VREFI;
      assign paChan[i]   = paAn[i] ? pinChan(i) : 4'h0;
      // Analog and reference inputs release the pin entirely.
      assign paOe[i] = (paAn[i] || paVrefIn[i]) ? 1'b0 :
                       (paFn[i] != IOP_FN_GPIO) ? 1'b1 :
                       ~paDirReg[i];
      assign paOut[i] = (paFn[i] == IOP_FN_TMR)   ? stdTimerOut   :
                        (paFn[i] == IOP_FN_TMRN)  ? stdTimerOutN  :
                        (paFn[i] == IOP_FN_REF_VOLTAGE_OUT) ? refVoltageOut :
                        paDataReg[i];
      assign paPullEn[i] = paPullReg[i] && paDirReg[i] &&
                           paFn[i] == IOP_FN_GPIO;
      assign paDigIn[i]  = paAn[i] ? 1'b0 : paIn[i];
   end

   assign paAnalogPin    = paAn;
   assign refVoltageInEn = |paVrefIn;

   // Every channel that is bonded to an analog pin sees that pin.
   always_comb begin
      analogChEn = 4'h0;
      for (int i = 0; i < 8; i++) begin
         analogChEn = analogChEn | paChan[i];
      end
   end

   // ****************************************************************
   // Ports B and C.
   // ****************************************************************
   assign pbOut    = pbDataReg;
   assign pbOe     = ~pbDirReg;
   assign pbPullEn = pbPullReg & pbDirReg;
   assign pcOut    = pcDataReg;
   assign pcOe     = ~pcDirReg;
   assign pcPullEn = pcPullReg & pcDirReg;

   // ****************************************************************
   // Wake-up and interrupt.
   // ****************************************************************
   wire logic [7:0] fallEvt = paWakeReg & paPrevReg & ~paIn;
   wire logic [7:0] wakeEvt = sleepMode ? fallEvt : `IOP_RST_ZERO;
   wire logic [7:0] irqStatNext = (irqStatReg & ~clrMask) | wakeEvt;

   assign wakeUp = wakeUpReg;
   assign irq    = |(irqStatReg & irqEnReg);

   // ****************************************************************
   // Read mux.
   // ****************************************************************
   wire logic [7:0] paRead = (paDirReg & paIn) | (~paDirReg & paDataReg);
   wire logic [7:0] pbRead = 8'((pbDirReg & pbIn) | (~pbDirReg & pbDataReg));
   wire logic [7:0] pcRead = 8'((pcDirReg & pcIn) | (~pcDirReg & pcDataReg));
   logic [7:0] rdMux;

   always_comb begin
      case (addr)
         `IOP_A_PA_DATA:  rdMux = paRead;
         `IOP_A_PA_DIR:   rdMux = paDirReg;
         `IOP_A_PA_PULL:  rdMux = paPullReg;
         `IOP_A_PA_WAKE:  rdMux = paWakeReg;
         `IOP_A_PA_SEL:   rdMux = paSelReg;
         `IOP_A_PB_DATA:  rdMux = pbRead;
         `IOP_A_PB_DIR:   rdMux = 8'(pbDirReg);
         `IOP_A_PB_PULL:  rdMux = 8'(pbPullReg);
         `IOP_A_PC_DATA:  rdMux = pcRead;
         `IOP_A_PC_DIR:   rdMux = 8'(pcDirReg);
         `IOP_A_PC_PULL:  rdMux = 8'(pcPullReg);
         `IOP_A_RST_CTRL: rdMux = rstCtrlReg;
         `IOP_A_IRQ_STAT: rdMux = irqStatReg;
         `IOP_A_IRQ_EN:   rdMux = irqEnReg;
         default:         rdMux = `IOP_RST_ZERO;
      endcase
   end

   assign rdData = rdDataReg;

   // ****************************************************************
   // Port A registers.
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         paDataReg <= `IOP_RST_DATA;
         paDirReg  <= `IOP_RST_DIR;
         paPullReg <= `IOP_RST_ZERO;
         paWakeReg <= `IOP_RST_ZERO;
         paSelReg  <= `IOP_RST_ZERO;
      end else begin
         if (wrPaData) paDataReg <= wrData;
         if (wrPaDir)  paDirReg  <= wrData;
         if (wrPaPull) paPullReg <= wrData;
         if (wrPaWake) paWakeReg <= wrData;
         if (wrPaSel)  paSelReg  <= wrData;
      end
   end

   // ****************************************************************
   // Port B and C registers.
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pbDataReg <= PB_WIDTH'(`IOP_RST_DATA);
         pbDirReg  <= PB_WIDTH'(`IOP_RST_DIR);
         pbPullReg <= PB_WIDTH'(`IOP_RST_ZERO);
         pcDataReg <= PC_WIDTH'(`IOP_RST_DATA);
         pcDirReg  <= PC_WIDTH'(`IOP_RST_DIR);
         pcPullReg <= PC_WIDTH'(`IOP_RST_ZERO);
      end else begin
         if (wrPbData) pbDataReg <= wrData[PB_WIDTH-1:0];
         if (wrPbDir)  pbDirReg  <= wrData[PB_WIDTH-1:0];
         if (wrPbPull) pbPullReg <= wrData[PB_WIDTH-1:0];
         if (wrPcData) pcDataReg <= wrData[PC_WIDTH-1:0];
         if (wrPcDir)  pcDirReg  <= wrData[PC_WIDTH-1:0];
         if (wrPcPull) pcPullReg <= wrData[PC_WIDTH-1:0];
      end
   end

   // ****************************************************************
   // Control, wake and read registers.
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rstCtrlReg <= `IOP_RST_CTRL;
         irqEnReg   <= `IOP_RST_ZERO;
         irqStatReg <= `IOP_RST_ZERO;
         paPrevReg  <= `IOP_RST_ZERO;
         wakeUpReg  <= 1'b0;
         rdDataReg  <= `IOP_RST_ZERO;
      end else begin
         if (wrRstCtrl) rstCtrlReg <= wrData;
         if (wrIrqEn)   irqEnReg   <= wrData;
         irqStatReg <= irqStatNext;
         paPrevReg  <= paIn;
         wakeUpReg  <= |wakeEvt;
         if (rdStrobe) rdDataReg <= rdMux;
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   a_pull_input_only: assert property (
      @(posedge clk) disable iff (rst)
      ((paPullEn & ~paDirReg) == 8'h00) && ((pbPullEn & ~pbDirReg) == '0))
      else $error("Pull-high active on an output pin.");

   a_upper_bits_zero: assert property (
      @(posedge clk) disable iff (rst)
      (rdStrobe && addr == `IOP_A_PB_DIR) |=> ((rdData >> PB_WIDTH) == 8'h00))
      else $error("Unused port B direction bits read non-zero.");

   a_wake_on_fall: assert property (
      @(posedge clk) disable iff (rst)
      (sleepMode && |(paWakeReg & $past(paIn) & ~paIn)) |=> wakeUp)
      else $error("Enabled falling edge in sleep did not wake.");

   a_no_wake_awake: assert property (
      @(posedge clk) disable iff (rst)
      !sleepMode |=> !wakeUp)
      else $error("Wake raised outside sleep.");

   a_dir_output: assert property (
      @(posedge clk) disable iff (rst)
      (wrPaDir && wrData == 8'h00 && paSelReg == 8'h00 && !wrPaSel)
      |=> (paOe == 8'hFF) && (paOut == $past(paDataReg)))
      else $error("Cleared direction did not drive the pins.");

   a_read_live_pin: assert property (
      @(posedge clk) disable iff (rst)
      (rdStrobe && addr == `IOP_A_PA_DATA && paDirReg == 8'hFF)
      |=> rdData == $past(paIn))
      else $error("Input read did not return the pin level.");

   a_read_latch: assert property (
      @(posedge clk) disable iff (rst)
      (rdStrobe && addr == `IOP_A_PA_DATA && paDirReg == 8'h00)
      |=> rdData == $past(paDataReg))
      else $error("Output read did not return the latch.");

   a_analog_release: assert property (
      @(posedge clk) disable iff (rst)
      (paOe & paAnalogPin) == 8'h00)
      else $error("Analog pin still driven.");

   a_set_beats_clear: assert property (
      @(posedge clk) disable iff (rst)
      (|(wakeEvt & clrMask)) |=> |(irqStatReg & $past(wakeEvt & clrMask)))
      else $error("Wake event lost to a same-cycle clear.");

   a_timer_drives: assert property (
      @(posedge clk) disable iff (rst)
      (VARIANT == IOP_VAR_SMALL && paSelReg[`IOP_SS_PA0] == 2'b01)
      |-> paOe[0] && paOut[0] == stdTimerOut)
      else $error("Timer output not driven on selected pin.");

endmodule : iop_port_pull_wake_mux
`default_nettype wire

// *** iop_pin_model.sv ***
// Board-side model of one port: board drivers, pull-ups and floating pins.
`timescale 1ns/1ps
`default_nettype none
module iop_pin_model #(
   parameter int W = 8
) (
   // Clock.
   input  wire logic         clk,
   // Device side.
   input  wire logic [W-1:0] pinOut,
   input  wire logic [W-1:0] pinOe,
   input  wire logic [W-1:0] pinPull,
   // Board side.
   input  wire logic [W-1:0] extVal,
   input  wire logic [W-1:0] extEn,
   output var  logic [W-1:0] pinLevel
);
   logic floatTog;
   initial floatTog = 1'b0;
   // A floating pin shows a pattern that changes every cycle.
   always @(posedge clk) floatTog <= ~floatTog;
   // A strong board driver wins over the device output.
   // An undriven input pin with its pull-high on reads high.
   always_comb pinLevel = (extEn & extVal) | (~extEn & pinOe & pinOut)
      | (~extEn & ~pinOe & pinPull) | (~extEn & ~pinOe & ~pinPull & {W{floatTog}});
endmodule : iop_pin_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench of the port block, small and mid variants.
`timescale 1ns/1ps
`default_nettype none
`include "iop_regs.svh"
module testbench;
   import iop_pkg::*;
   logic clk = 0, rst = 1, wrStrobe = 0, rdStrobe = 0, sleepMode = 0;
   logic [3:0] addr = 0, analogChEn;
   logic [7:0] wrData = 0, rdData, rv, paIn, paOut, paOe, paPullEn;
   logic [7:0] paDigIn, paAnalogPin, extVal = 0, extEn = 0;
   logic [5:0] pbIn, pbOut, pbOe, pbPull;
   logic [2:0] pcIn, pcOut, pcOe, pcPull;
   logic refVoltageInEn, wakeUp, irq;
   logic [7:0] mOut, mOe, mAn, bcEn = 0, bcVal = 0;
   logic [3:0] mCh;
   logic mRef, tmrOut = 1, tmrOutN = 0, vrefOut = 1;
   int num_errors = 0, n_compared = 0, cycles = 0;
   always #2 clk = ~clk;
   iop_port_pull_wake_mux dut_u (.clk(clk), .rst(rst), .addr(addr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
      .rdData(rdData), .paIn(paIn), .paOut(paOut), .paOe(paOe),
      .paPullEn(paPullEn), .pbIn(pbIn), .pbOut(pbOut), .pbOe(pbOe),
      .pbPullEn(pbPull), .pcIn(pcIn), .pcOut(pcOut), .pcOe(pcOe),
      .pcPullEn(pcPull), .stdTimerOut(tmrOut), .stdTimerOutN(tmrOutN),
      .refVoltageOut(vrefOut), .paDigIn(paDigIn), .paAnalogPin(paAnalogPin),
      .analogChEn(analogChEn), .refVoltageInEn(refVoltageInEn),
      .sleepMode(sleepMode), .wakeUp(wakeUp), .irq(irq));
   iop_pin_model #(.W(8)) pin_a_u (.clk(clk), .pinOut(paOut), .pinOe(paOe),
      .pinPull(paPullEn), .extVal(extVal), .extEn(extEn), .pinLevel(paIn));
   iop_pin_model #(.W(6)) pin_b_u (.clk(clk), .pinOut(pbOut), .pinOe(pbOe),
      .pinPull(pbPull), .extVal(bcVal[5:0]), .extEn(bcEn[5:0]),
      .pinLevel(pbIn));
   iop_pin_model #(.W(3)) pin_c_u (.clk(clk), .pinOut(pcOut), .pinOe(pcOe),
      .pinPull(pcPull), .extVal(bcVal[2:0]), .extEn(bcEn[2:0]),
      .pinLevel(pcIn));
   iop_port_pull_wake_mux #(.VARIANT(IOP_VAR_MID)) dut_mid_u (.clk(clk),
      .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .rdData(), .paIn(paIn), .paOut(mOut),
      .paOe(mOe), .paPullEn(), .pbIn(pbIn), .pbOut(), .pbOe(), .pbPullEn(),
      .pcIn(pcIn), .pcOut(), .pcOe(), .pcPullEn(), .stdTimerOut(tmrOut),
      .stdTimerOutN(tmrOutN), .refVoltageOut(vrefOut), .paDigIn(),
      .paAnalogPin(mAn), .analogChEn(mCh), .refVoltageInEn(mRef),
      .sleepMode(sleepMode), .wakeUp(), .irq());
   // ****************************************************************
   // Bus access, comparison and closing.
   // ****************************************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wrStrobe <= 1'b1;
      addr <= a;
      wrData <= d;
      @(posedge clk);
      wrStrobe <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      rdStrobe <= 1'b1;
      addr <= a;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1;
      rv = rdData;
   endtask : rd
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   logic [3:0] ra [12] = '{1, 2, 3, 4, 6, 7, 9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
   logic [7:0] re [12] = '{8'hFF, 0, 0, 0, 8'h3F, 0, 8'h07, 0, 0, 0, 0, 0};
   logic [7:0] sv [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
   logic [7:0] oe [4] = '{8'h00, 8'h27, 8'h04, 8'h00};
   logic [7:0] pu [4] = '{8'hFF, 8'hD8, 8'hF9, 8'hD8};
   logic [7:0] dg [4] = '{8'hFD, 8'hDD, 8'hFD, 8'hD8};
   logic [7:0] po [4] = '{8'h00, 8'h05, 8'h04, 8'h00};
   logic [7:0] mo [4] = '{8'h00, 8'h40, 8'h10, 8'h50};
   logic [7:0] ma [4] = '{8'h00, 8'h09, 8'h04, 8'h0F};
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[i]) begin
         rd(ra[i]);
         chk(rv, re[i]);
      end
      wr(4'h7, 8'hFF);
      rd(4'h7);
      chk(rv, 8'h3F);
      wr(4'hA, 8'hFF);
      rd(4'hA);
      chk(rv, 8'h07);
      chk(pbPull, 8'h3F);
      chk(pcPull, 8'h07);
      wr(4'h6, 8'h00);
      wr(4'h5, 8'h2A);
      chk(pbOe, 8'h3F);
      chk(pbOut, 8'h2A);
      chk(pbPull, 8'h00);
      rd(4'h5);
      chk(rv, 8'h2A);
      bcEn <= 8'hFF;
      bcVal <= 8'h15;
      wr(4'h6, 8'hFF);
      rd(4'h5);
      chk(rv, 8'h15);
      rd(4'h8);
      chk(rv, 8'h05);
      chk(pcOe, 8'h00);
      bcEn <= 8'h00;
      wr(4'h2, 8'hFF);
      chk(paPullEn, 8'hFF);
      wr(4'h1, 8'hF0);
      chk(paOe, 8'h0F);
      chk(paPullEn, 8'hF0);
      extEn <= 8'hFF;
      extVal <= 8'hA5;
      wr(4'h0, 8'h5A);
      wr(4'h1, 8'h00);
      chk(paOut, 8'h5A);
      rd(4'h0);
      chk(rv, 8'h5A);
      wr(4'h1, 8'hFF);
      rd(4'h0);
      chk(rv, 8'hA5);
      extEn <= 8'h00;
      wr(4'h0, 8'h00);
      foreach (sv[i]) begin
         wr(4'h4, sv[i]);
         @(posedge clk);
         #1;
         chk(paOe, oe[i]);
         chk(paOut, po[i]);
         chk(mOe, mo[i]);
         chk(mOut, mo[i]);
         chk(mAn, ma[i]);
         chk(mCh, ma[i]);
         chk(mRef, (i == 1) ? 8'h01 : 8'h00);
         chk(paPullEn, pu[i]);
         chk(paDigIn & 8'hFD, dg[i]);
         chk(paAnalogPin, (i == 3) ? 8'h27 : 8'h00);
         chk(analogChEn, (i == 3) ? 8'h0F : 8'h00);
         chk(refVoltageInEn, (i == 2) ? 8'h01 : 8'h00);
      end
      wr(4'hB, 8'h55);
      chk(mOe, 8'hD0);
      chk(mOut, 8'h50);
      wr(4'h4, 8'h00);
      extEn <= 8'hFF;
      extVal <= 8'hFF;
      wr(4'h3, 8'h01);
      wr(4'hE, 8'h01);
      sleepMode <= 1'b1;
      @(posedge clk);
      extVal <= 8'hFE;
      @(posedge clk);
      #1;
      chk(wakeUp, 8'h01);
      @(posedge clk);
      #1;
      chk(wakeUp, 8'h00);
      chk(irq, 8'h01);
      rd(4'hC);
      chk(rv, 8'h01);
      @(posedge clk);
      extVal <= 8'hFC;
      repeat (2) @(posedge clk);
      #1;
      chk(wakeUp, 8'h00);
      wr(4'hD, 8'h01);
      chk(irq, 8'h00);
      rd(4'hC);
      chk(rv, 8'h00);
      wr(4'hE, 8'h00);
      sleepMode <= 1'b0;
      extVal <= 8'hFF;
      @(posedge clk);
      extVal <= 8'hFE;
      repeat (2) @(posedge clk);
      #1;
      chk(wakeUp, 8'h00);
      sleepMode <= 1'b1;
      extVal <= 8'hFF;
      @(posedge clk);
      extVal <= 8'hFE;
      repeat (2) @(posedge clk);
      #1;
      chk(irq, 8'h00);
      rd(4'hC);
      chk(rv, 8'h01);
      wr(4'hD, 8'h01);
      extVal <= 8'hFF;
      fork
         wr(4'hD, 8'h01);
         begin
            @(posedge clk);
            extVal <= 8'hFE;
         end
      join
      rd(4'hC);
      chk(rv, 8'h01);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
